// *** src/prsr_pkg.sv ***
// Purpose: Shared constants for the proximity result and status register block.
// Assumes: 250 MHz core clock, byte-wide register port from the serial engine.
// Notes: Offsets are byte addresses as seen on the register port.
package prsr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_PULSE_CONFIG = 8'h8f;
  localparam logic [7:0] ADDR_REVISION = 8'h91;
  localparam logic [7:0] ADDR_DEVICE_TYPE = 8'h92;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h9b;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h9c;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h9d;
  // Reset values; pulse width code 3, current code 0
  localparam logic [7:0] PULSE_CONFIG_RESET = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Field positions in pulse_config
  localparam int PW_MSB = 7;
  localparam int PW_LSB = 5;
  localparam int CUR_MSB = 3;
  localparam int CUR_LSB = 0;
  // Bit positions in event_flags
  localparam int FLAG_ABOVE_HIGH = 7;
  localparam int FLAG_BELOW_LOW = 6;
  localparam int FLAG_ANY_SAT = 5;
  localparam int FLAG_PROX_EVENT = 4;
  localparam int FLAG_CAL_DONE = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_EMITTER_ON_SAT = 1;
  localparam int FLAG_EMITTER_OFF_SAT = 0;
  // Legal emitter current codes
  localparam logic [3:0] CURRENT_CODE_MIN = 4'h5;
  localparam logic [3:0] CURRENT_CODE_MAX = 4'h8;
  // Pulse widths in microseconds per width code
  localparam int PULSE_WIDTH_US [8] = '{1, 2, 4, 8, 12, 16, 24, 32};
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_US = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Result scaling with automatic pulse control
  localparam int APC_SCALE_SHIFT = 4;
  localparam logic [3:0] PERSIST_SAT = 4'hf;
  // Pulse sequencer states
  typedef enum logic [2:0] {
    PRSR_IDLE = 3'b001,
    PRSR_PULSE_ON = 3'b010,
    PRSR_PULSE_OFF = 3'b100
  } prsr_seq_state_type;
endpackage : prsr_pkg

// *** src/prsr_pulse_seq.sv ***
// Purpose: Emitter pulse train for one proximity cycle.
// Assumes: start, near_sat are synchronous to core_clk.
// Notes: Gap between pulses equals the pulse width.
`timescale 1ns/1ps
module prsr_pulse_seq #(
  parameter int UNIT_CYCLES = prsr_pkg::CYCLES_PER_US
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [2:0] width_sel,
  input wire logic [5:0] pulse_max,
  input wire logic apc_enable,
  input wire logic near_sat,
  output logic emitter_on,
  output logic done,
  output logic [6:0] pulse_count
);
  import prsr_pkg::*;

  // Longest pulse must fit the 16-bit tick counter; refused at elaboration
  if (UNIT_CYCLES < 1 || UNIT_CYCLES * 32 > 65535) begin : g_unit_check
    $error("UNIT_CYCLES out of range");
  end

  prsr_seq_state_type state;
  logic [15:0] width_cycles;
  logic [15:0] tick;
  logic [6:0] pulses;
  logic last_pulse;

  // Width lookup; the largest width needs 16 bits of count
  always_comb begin
    width_cycles = 16'(PULSE_WIDTH_US[width_sel] * UNIT_CYCLES);
  end

  assign last_pulse = (pulses == {1'b0, pulse_max}) || (apc_enable && near_sat);
  assign emitter_on = (state == PRSR_PULSE_ON);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= PRSR_IDLE;
      tick <= 16'h0000;
      pulses <= 7'h00;
      done <= 1'b0;
      pulse_count <= 7'h00;
    end else begin
      done <= 1'b0;
      unique case (state)
        PRSR_IDLE: begin
          if (start) begin
            state <= PRSR_PULSE_ON;
            tick <= width_cycles - 16'h0001;
            pulses <= 7'h00;
          end
        end
        PRSR_PULSE_ON: begin
          if (tick == 16'h0000) begin
            if (last_pulse) begin
              state <= PRSR_IDLE;
              done <= 1'b1;
              pulse_count <= pulses + 7'h01;
            end else begin
              state <= PRSR_PULSE_OFF;
              tick <= width_cycles - 16'h0001;
            end
            pulses <= pulses + 7'h01;
          end else begin
            tick <= tick - 16'h0001;
          end
        end
        PRSR_PULSE_OFF: begin
          if (tick == 16'h0000) begin
            state <= PRSR_PULSE_ON;
            tick <= width_cycles - 16'h0001;
          end else begin
            tick <= tick - 16'h0001;
          end
        end
      endcase
    end
  end

  // Helper: length of the current high phase
  logic [15:0] on_len;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      on_len <= 16'h0000;
    end else begin
      on_len <= emitter_on ? on_len + 16'h0001 : 16'h0000;
    end
  end

  property p_pulse_width;
    @(posedge core_clk) disable iff (!resetn)
    $fell(emitter_on) |-> on_len == 16'(PULSE_WIDTH_US[$past(width_sel)] * UNIT_CYCLES);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("emitter pulse width wrong");

  property p_pulse_max;
    @(posedge core_clk) disable iff (!resetn)
    done |-> pulse_count <= {1'b0, pulse_max} + 7'h01;
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("pulse count above maximum");

  c_apc_stop: cover property (@(posedge core_clk) disable iff (!resetn) done && apc_enable && pulse_count == 7'h01);
endmodule : prsr_pulse_seq

// *** src/prsr_regs.sv ***
// Purpose: Proximity pulse settings, identity, event flags and result registers.
// Assumes: Register port strobes come from the serial engine on core_clk.
// Notes: Engine events and config bits of other registers arrive as plain ports.
//
// Summary of operation
// - Pulse width code selects 1 to 32 us
// - Current codes 5 to 8 only legal
// - Above-high bit sets with event flag
// - Below-low bit sets with event flag
// - Saturation bit on any saturation event
// - Event flag after persistence count reached
// - Calibration-done bit on calibration finish
// - Zero bit on offset decrement, auto-adjust
// - Emitter-on saturation sets bit one
// - Emitter-off saturation sets bit zero
// - Writing one clears the flag bit
// - Status read clears all when enabled
// - Low byte read latches high byte
// - Strong signal ends pulse train early
// - Result scaled by sixteen over pulses
// - Result bytes hold fourteen-bit value
// - Pulse control off gives 10-bit packing
// - Pulse control off compares upper bits
// - Consecutive out-of-range count versus persistence
// - Read-clear enable is a config bit
`timescale 1ns/1ps
module prsr_regs #(
  parameter int PULSE_UNIT_CYCLES = prsr_pkg::CYCLES_PER_US,
  parameter logic [7:0] REVISION_CODE = 8'h0a,   // Arbitrary value
  parameter logic [7:0] DEVICE_TYPE_CODE = 8'h5c // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic apc_disable,
  input wire logic read_clear_enable,
  input wire logic automatic_offset_adjust,
  input wire logic [3:0] persistence_count,
  input wire logic [13:0] high_threshold,
  input wire logic [13:0] low_threshold,
  input wire logic [5:0] pulse_max,
  input wire logic cycle_start,
  input wire logic near_saturation,
  input wire logic adc_valid,
  input wire logic [9:0] adc_value,
  input wire logic ambient_sat_event,
  input wire logic reflective_sat_event,
  input wire logic calibration_done,
  input wire logic offset_decrement,
  output logic emitter_on,
  output logic [2:0] emitter_pulse_width_sel,
  output logic [3:0] emitter_current_sel,
  output logic emitter_current_legal,
  output logic [6:0] pulse_count,
  output logic [13:0] proximity_result,
  output logic proximity_event_flag
);
  import prsr_pkg::*;

  logic [7:0] pulse_config;
  logic [7:0] event_flags;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;
  logic [7:0] high_shadow;
  logic [3:0] persist_cnt;
  logic [3:0] next_persist_cnt;
  logic [13:0] next_result;
  logic [6:0] divisor;
  logic out_high;
  logic out_low;
  logic persist_fire;
  logic [7:0] set_vec;
  logic [7:0] clr_base;
  logic [7:0] clr_vec;
  logic wr_flags;
  logic rd_flags;

  assign wr_flags = reg_wr && (reg_addr == ADDR_EVENT_FLAGS);
  assign rd_flags = reg_rd && (reg_addr == ADDR_EVENT_FLAGS);

  // Pulse configuration register, all eight bits writable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_config <= PULSE_CONFIG_RESET;
    end else if (reg_wr && reg_addr == ADDR_PULSE_CONFIG) begin
      pulse_config <= reg_wdata;
    end
  end

  assign emitter_pulse_width_sel = pulse_config[PW_MSB:PW_LSB];
  assign emitter_current_sel = pulse_config[CUR_MSB:CUR_LSB];
  // legal current codes
  // Reserved codes are stored but flagged so the driver can refuse them
  assign emitter_current_legal = (emitter_current_sel >= CURRENT_CODE_MIN)
                                 && (emitter_current_sel <= CURRENT_CODE_MAX);

  // Pulse train; pulse control on unless config_reg_six disables it
  prsr_pulse_seq #(
    .UNIT_CYCLES(PULSE_UNIT_CYCLES)
  ) u_seq (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(cycle_start),
    .width_sel(emitter_pulse_width_sel),
    .pulse_max(pulse_max),
    .apc_enable(!apc_disable),
    .near_sat(near_saturation),
    .emitter_on(emitter_on),
    .done(),
    .pulse_count(pulse_count)
  );

  // scale by 16 over pulses
  // A zero pulse count cannot occur after a train; treat it as one to avoid divide by zero
  always_comb begin
    divisor = (pulse_count == 7'h00) ? 7'h01 : pulse_count;
    if (apc_disable) begin
      next_result = {4'h0, adc_value};
    end else begin
      next_result = 14'(({4'h0, adc_value} << APC_SCALE_SHIFT) / {7'h00, divisor});
    end
  end

  always_comb begin
    if (apc_disable) begin
      out_high = adc_value[9:2] > high_threshold[7:0];
      out_low = adc_value[9:2] < low_threshold[7:0];
    end else begin
      out_high = next_result > high_threshold;
      out_low = next_result < low_threshold;
    end
  end

  always_comb begin
    if (!(out_high || out_low)) begin
      next_persist_cnt = 4'h0;
    end else if (persist_cnt == PERSIST_SAT) begin
      next_persist_cnt = PERSIST_SAT;
    end else begin
      next_persist_cnt = persist_cnt + 4'h1;
    end
    persist_fire = adc_valid && ((persistence_count == 4'h0)
                   || ((out_high || out_low) && next_persist_cnt == persistence_count));
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      persist_cnt <= 4'h0;
    end else if (adc_valid) begin
      persist_cnt <= next_persist_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_low_byte <= RESULT_RESET;
      result_high_byte <= RESULT_RESET;
      proximity_result <= 14'h0000;
    end else if (adc_valid) begin
      proximity_result <= next_result;
      if (apc_disable) begin
        result_low_byte <= adc_value[9:2];
        result_high_byte <= {6'h00, adc_value[1:0]};
      end else begin
        result_low_byte <= next_result[7:0];
        result_high_byte <= {2'h0, next_result[13:8]};
      end
    end
  end

  // low read latches high
  // Shadow keeps a high byte read coherent even if a new result lands between reads
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_shadow <= RESULT_RESET;
    end else if (reg_rd && reg_addr == ADDR_RESULT_LOW) begin
      high_shadow <= result_high_byte;
    end
  end

  // Hardware events per flag bit
  always_comb begin
    set_vec = 8'h00;
    set_vec[FLAG_PROX_EVENT] = persist_fire;
    set_vec[FLAG_ABOVE_HIGH] = persist_fire && out_high;
    set_vec[FLAG_BELOW_LOW] = persist_fire && out_low;
    set_vec[FLAG_ANY_SAT] = ambient_sat_event || reflective_sat_event;
    set_vec[FLAG_CAL_DONE] = calibration_done;
    set_vec[FLAG_ZERO] = offset_decrement && automatic_offset_adjust;
    set_vec[FLAG_EMITTER_ON_SAT] = reflective_sat_event;
    set_vec[FLAG_EMITTER_OFF_SAT] = ambient_sat_event;
  end

  // Host clears; rdata samples the old flags in the same edge so the read sees them
  always_comb begin
    clr_base = wr_flags ? reg_wdata : 8'h00;
    if (rd_flags && read_clear_enable) begin
      clr_base = 8'hff;
    end
    clr_vec = clr_base;
    if (clr_base[FLAG_PROX_EVENT] && !set_vec[FLAG_PROX_EVENT]) begin
      clr_vec[FLAG_ABOVE_HIGH] = 1'b1;
      clr_vec[FLAG_BELOW_LOW] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      event_flags <= FLAGS_RESET;
    end else begin
      event_flags <= (event_flags & ~clr_vec) | set_vec;
    end
  end

  assign proximity_event_flag = event_flags[FLAG_PROX_EVENT];

  // Read mux, registered; unmapped offsets answer zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= UNMAPPED_READ;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PULSE_CONFIG: reg_rdata <= pulse_config;
        ADDR_REVISION: reg_rdata <= REVISION_CODE;
        ADDR_DEVICE_TYPE: reg_rdata <= DEVICE_TYPE_CODE;
        ADDR_EVENT_FLAGS: reg_rdata <= event_flags;
        ADDR_RESULT_LOW: reg_rdata <= result_low_byte;
        ADDR_RESULT_HIGH: reg_rdata <= high_shadow;
        default: reg_rdata <= UNMAPPED_READ;
      endcase
    end
  end

  property p_w1c;
    @(posedge core_clk) disable iff (!resetn)
    wr_flags && reg_wdata[FLAG_CAL_DONE] && !calibration_done |=> !event_flags[FLAG_CAL_DONE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_set_wins;
    @(posedge core_clk) disable iff (!resetn)
    wr_flags && reg_wdata[FLAG_CAL_DONE] && calibration_done |=> event_flags[FLAG_CAL_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a coincident set");

  property p_read_clear;
    @(posedge core_clk) disable iff (!resetn)
    rd_flags && read_clear_enable && set_vec == 8'h00 |=> event_flags == 8'h00 && reg_rdata == $past(event_flags);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read clear failed");

  property p_high_needs_event;
    @(posedge core_clk) disable iff (!resetn)
    event_flags[FLAG_ABOVE_HIGH] || event_flags[FLAG_BELOW_LOW] |-> event_flags[FLAG_PROX_EVENT];
  endproperty
  a_high_needs_event: assert property (p_high_needs_event) else $error("threshold bit without event");

  property p_sat;
    @(posedge core_clk) disable iff (!resetn)
    ambient_sat_event |=> event_flags[FLAG_ANY_SAT] && event_flags[FLAG_EMITTER_OFF_SAT];
  endproperty
  a_sat: assert property (p_sat) else $error("saturation flags not set");

  property p_result_apc;
    @(posedge core_clk) disable iff (!resetn)
    adc_valid && !apc_disable && pulse_count == 7'h10
      |=> {result_high_byte[5:0], result_low_byte} == {4'h0, $past(adc_value)};
  endproperty
  a_result_apc: assert property (p_result_apc) else $error("scaled result wrong");

  property p_result_raw;
    @(posedge core_clk) disable iff (!resetn)
    adc_valid && apc_disable |=> {result_low_byte, result_high_byte[1:0]} == $past(adc_value)
      && result_high_byte[7:2] == 6'h00;
  endproperty
  a_result_raw: assert property (p_result_raw) else $error("10-bit packing wrong");

  property p_latch;
    @(posedge core_clk) disable iff (!resetn)
    reg_rd && reg_addr == ADDR_RESULT_LOW ##1 reg_rd && reg_addr == ADDR_RESULT_HIGH
      |=> reg_rdata == $past(result_high_byte, 2);
  endproperty
  a_latch: assert property (p_latch) else $error("high byte not coherent");

  property p_pers_every;
    @(posedge core_clk) disable iff (!resetn)
    adc_valid && persistence_count == 4'h0 |=> event_flags[FLAG_PROX_EVENT];
  endproperty
  a_pers_every: assert property (p_pers_every) else $error("persistence zero missed event");

  c_high_event: cover property (@(posedge core_clk) disable iff (!resetn) $rose(event_flags[FLAG_ABOVE_HIGH]));
  c_read_clear: cover property (@(posedge core_clk) disable iff (!resetn) rd_flags && read_clear_enable
    && event_flags != 8'h00);
  c_latch: cover property (@(posedge core_clk) disable iff (!resetn) reg_rd && reg_addr == ADDR_RESULT_HIGH);
endmodule : prsr_regs

// *** tb/prsr_host.sv ***
// Purpose: Host model on the byte register port of the proximity block.
// Assumes: Requests change 1 ns after a rising core_clk edge.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
module prsr_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // one byte write
  // Only bits meant to be cleared are written as ones; current codes stay legal
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~addr; // Released lines keep moving
    reg_wdata = ~data;
  endtask : wr

  // One byte read; data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
  endtask : rd

  // low then high
  // Back-to-back strobes, so the high read follows the latching low read directly
  task automatic rd_pair(input logic [7:0] addr, output logic [7:0] lo, output logic [7:0] hi);
    @(posedge core_clk);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_addr = addr + 8'h01; // High byte sits right after the low byte
    lo = reg_rdata;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    hi = reg_rdata;
  endtask : rd_pair
endmodule : prsr_host

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the proximity result and status registers.
// Assumes: Short pulse unit of 2 cycles; inputs change 1 ns after the edge.
// Notes: Each scenario is one task that drives and judges on its own.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  import prsr_pkg::*;
  localparam int UNIT = 2;
  localparam logic [7:0] REV_CODE = 8'h3c; // Arbitrary value
  localparam logic [7:0] TYPE_CODE = 8'ha5; // Arbitrary value
  int n_errors = 0;
  int n_tests = 0;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rb, rb2;
  logic reg_wr, reg_rd, emitter_on, emitter_current_legal, proximity_event_flag;
  logic apc_disable = 1'b0, read_clear_enable = 1'b0, automatic_offset_adjust = 1'b0;
  logic [3:0] persistence_count = 4'h1;
  logic [13:0] high_threshold = 14'h3fff, low_threshold = 14'h0000, proximity_result;
  logic [5:0] pulse_max = 6'h00;
  logic cycle_start = 1'b0, near_saturation = 1'b0, adc_valid = 1'b0;
  logic [9:0] adc_value = 10'h000;
  logic ambient_sat_event = 1'b0, reflective_sat_event = 1'b0;
  logic calibration_done = 1'b0, offset_decrement = 1'b0;
  logic [2:0] emitter_pulse_width_sel;
  logic [3:0] emitter_current_sel;
  logic [6:0] pulse_count;

  // Clock, 4 ns period
  always #2 core_clk = ~core_clk;

  prsr_host u_prsr_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  prsr_regs #(.PULSE_UNIT_CYCLES(UNIT), .REVISION_CODE(REV_CODE), .DEVICE_TYPE_CODE(TYPE_CODE)) u_prsr_regs (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .apc_disable(apc_disable),
    .read_clear_enable(read_clear_enable), .automatic_offset_adjust(automatic_offset_adjust),
    .persistence_count(persistence_count), .high_threshold(high_threshold), .low_threshold(low_threshold),
    .pulse_max(pulse_max), .cycle_start(cycle_start), .near_saturation(near_saturation),
    .adc_valid(adc_valid), .adc_value(adc_value), .ambient_sat_event(ambient_sat_event),
    .reflective_sat_event(reflective_sat_event), .calibration_done(calibration_done),
    .offset_decrement(offset_decrement), .emitter_on(emitter_on),
    .emitter_pulse_width_sel(emitter_pulse_width_sel), .emitter_current_sel(emitter_current_sel),
    .emitter_current_legal(emitter_current_legal), .pulse_count(pulse_count),
    .proximity_result(proximity_result), .proximity_event_flag(proximity_event_flag));

  // Engine event pulse: {ambient, reflective, calibration, offset}
  task automatic ev(input logic [3:0] sel);
    @(posedge core_clk);
    #1;
    {ambient_sat_event, reflective_sat_event, calibration_done, offset_decrement} = sel;
    @(posedge core_clk);
    #1;
    {ambient_sat_event, reflective_sat_event, calibration_done, offset_decrement} = 4'h0;
  endtask : ev

  // One conversion result; the data line moves once the strobe drops
  task automatic adc(input logic [9:0] v);
    @(posedge core_clk);
    #1;
    adc_value = v;
    adc_valid = 1'b1;
    @(posedge core_clk);
    #1;
    adc_valid = 1'b0;
    adc_value = ~v;
  endtask : adc

  // Pulse train: counts emitter high cycles over the longest possible train
  task automatic train(input logic [2:0] w, input logic [5:0] pmax, input logic nsat, input logic [6:0] n);
    int hi;
    int wc;
    hi = 0;
    wc = PULSE_WIDTH_US[w] * UNIT;
    u_prsr_host.wr(ADDR_PULSE_CONFIG, {w, 1'b0, 4'h5});
    @(posedge core_clk);
    #1;
    pulse_max = pmax;
    near_saturation = nsat;
    cycle_start = 1'b1;
    @(posedge core_clk);
    #1;
    cycle_start = 1'b0;
    repeat (2 * wc * (int'(pmax) + 1) + 8) begin
      if (emitter_on === 1'b1) hi++;
      @(posedge core_clk);
      #1;
    end
    `CHK(hi, int'(n) * wc)
    `CHK(pulse_count, n)
  endtask : train

  // Reset values, identity codes, read-only and unmapped places
  task automatic t_reset_values();
    `CHK(emitter_pulse_width_sel, PULSE_CONFIG_RESET[7:5])
    `CHK(emitter_current_legal, 1'b0)
    u_prsr_host.wr(ADDR_REVISION, 8'hff);
    u_prsr_host.rd(ADDR_PULSE_CONFIG, rb); `CHK(rb, PULSE_CONFIG_RESET)
    u_prsr_host.rd(ADDR_REVISION, rb); `CHK(rb, REV_CODE)
    u_prsr_host.rd(ADDR_DEVICE_TYPE, rb); `CHK(rb, TYPE_CODE)
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, FLAGS_RESET)
    u_prsr_host.rd(ADDR_RESULT_HIGH, rb); `CHK(rb, RESULT_RESET)
    u_prsr_host.rd(8'h90, rb); `CHK(rb, UNMAPPED_READ)
  endtask : t_reset_values

  // Every legal current code; the host never writes a reserved one
  task automatic t_current();
    for (int c = 5; c <= 8; c++) begin
      u_prsr_host.wr(ADDR_PULSE_CONFIG, {3'h2, 1'b0, 4'(c)});
      `CHK(emitter_current_sel, 4'(c))
      `CHK(emitter_current_legal, 1'(c >= 5 && c <= 8))
      `CHK(emitter_pulse_width_sel, 3'h2)
    end
  endtask : t_current

  // Scaled results, byte packing and the low-first latch
  task automatic t_apc_result();
    train(3'h0, 6'h05, 1'b1, 7'd1);
    adc(10'd100);
    `CHK(proximity_result, 14'd1600)
    u_prsr_host.rd(ADDR_RESULT_LOW, rb); `CHK(rb, 8'h40)
    adc(10'd3);
    u_prsr_host.rd(ADDR_RESULT_HIGH, rb); `CHK(rb, 8'h06)
    train(3'h0, 6'h03, 1'b0, 7'd4);
    adc(10'd1023);
    `CHK(proximity_result, 14'd4092)
    u_prsr_host.rd_pair(ADDR_RESULT_LOW, rb, rb2); `CHK(rb, 8'hfc)
    `CHK(rb2, 8'h0f)
    apc_disable = 1'b1;
    adc(10'h2b7);
    `CHK(proximity_result, 14'h02b7)
    u_prsr_host.rd(ADDR_RESULT_LOW, rb); `CHK(rb, 8'had)
    u_prsr_host.rd(ADDR_RESULT_HIGH, rb); `CHK(rb, 8'h03)
    apc_disable = 1'b0;
  endtask : t_apc_result

  // Event flags, write-one clear, coincident set and read clear
  task automatic t_flags();
    ev(4'b0010);
    ev(4'b0001);
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h08)
    automatic_offset_adjust = 1'b1;
    ev(4'b0001);
    ev(4'b0100);
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h2e)
    ev(4'b1000);
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h2f)
    u_prsr_host.wr(ADDR_EVENT_FLAGS, 8'h08);
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h27)
    fork
      u_prsr_host.wr(ADDR_EVENT_FLAGS, 8'h04);
      ev(4'b0001);
    join
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h27)
    read_clear_enable = 1'b1;
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h27)
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h00)
    read_clear_enable = 1'b0;
  endtask : t_flags

  // Persistence run, threshold flags and the 8-bit compare with pulse control off
  task automatic t_persistence();
    persistence_count = 4'h2;
    high_threshold = 14'd1000;
    low_threshold = 14'd100;
    train(3'h0, 6'h0f, 1'b0, 7'd16);
    adc(10'd1000);
    adc(10'd1001);
    adc(10'd500);
    adc(10'd1001);
    `CHK(proximity_event_flag, 1'b0)
    adc(10'd1001);
    `CHK(proximity_event_flag, 1'b1)
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h90)
    u_prsr_host.wr(ADDR_EVENT_FLAGS, 8'h10);
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h00)
    adc(10'd500); // In range, so the out-of-range run starts again
    adc(10'd99);
    adc(10'd99);
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h50)
    u_prsr_host.wr(ADDR_EVENT_FLAGS, 8'h10);
    apc_disable = 1'b1;
    persistence_count = 4'h1;
    high_threshold = 14'h3f10;
    low_threshold = 14'h0005;
    adc({8'h08, 2'b00}); // In range, restarts the run
    adc({8'h20, 2'b00});
    `CHK(proximity_event_flag, 1'b1)
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h90)
    // Persistence zero raises the event on any result
    u_prsr_host.wr(ADDR_EVENT_FLAGS, 8'h10);
    persistence_count = 4'h0;
    adc({8'h08, 2'b00});
    u_prsr_host.rd(ADDR_EVENT_FLAGS, rb); `CHK(rb, 8'h10)
  endtask : t_persistence

  // Verdict and end of run
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_reset_values();
    t_current();
    for (int w = 0; w < 8; w++) train(3'(w), 6'h00, 1'b0, 7'd1);
    t_apc_result();
    t_flags();
    t_persistence();
    give_verdict();
  end

  // Watchdog: the run needs under a thousand cycles, this allows 50000
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : testbench
